// [logic/quad_cfg_defs.vh]
`ifndef QUAD_CFG_DEFS_VH
`define QUAD_CFG_DEFS_VH

// byte addresses within one quad on the configuration port
`define QCFG_ADDR_VOLT 2'h0
`define QCFG_ADDR_CURR 2'h1
`define QCFG_ADDR_GATE 2'h2
`define QCFG_ADDR_TEMP 2'h3

// pad byte fields
`define QCFG_PRESC_LSB 0
`define QCFG_PRESC_MSB 2
`define QCFG_MUX_LSB 3
`define QCFG_MUX_MSB 4
`define QCFG_CMON_BIT 4
`define QCFG_DIRECT_BIT 5
`define QCFG_POL_BIT 6
`define QCFG_AMP_BIT 7

// gate driver byte fields
`define QCFG_TMON_BIT 0
`define QCFG_DRV_LSB 2
`define QCFG_DRV_MSB 3
`define QCFG_GPOL_BIT 6
`define QCFG_HIGH_BIT 7

// mux selector codes
`define QCFG_MUX_PRESC 2'h0
`define QCFG_MUX_DIRECT 2'h1
`define QCFG_MUX_MONITOR 2'h2

// reset values: highest range, prescaler path, switches off, amp down
`define QCFG_PAD_RST 8'h00
`define QCFG_GATE_RST 8'h00

`endif

// [logic/analog_quad_config_decode.v]
// Behaviour
// - mux field 00 prescaler, 01 direct, 10 monitor
// - pad bit 5 closes direct input switch
// - voltage and current pad bit 6 selects negative polarity
// - pad bit 7 powers prescaler amplifier
// - voltage byte bit 4 enables current monitor
// - gate bits 3:2 select 1/3/10/30 uA
// - gate bit 6 selects driver polarity
// - driver off unless on; bit 7 high drive
// - temp monitor on needs bit 0 and power
// - prescaler code doubles scaling, 0.15625 to 20
// - defaults after reset until configured
`include "quad_cfg_defs.vh"
`default_nettype none

module analog_quad_config_decode (
    input wire clk_sys,
    input wire rst,
    input wire cfg_wr,
    input wire [1:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    output reg [7:0] cfg_rdata,
    input wire gate_driver_on,
    input wire temp_monitor_power_ctl,
    output reg [2:0] volt_presc_sel,
    output reg [2:0] curr_presc_sel,
    output reg [2:0] temp_presc_sel,
    output reg [2:0] volt_mux_sel,
    output reg [2:0] curr_mux_sel,
    output reg [2:0] temp_mux_sel,
    output reg [2:0] direct_sw,
    output reg [2:0] pol_negative,
    output reg [2:0] amp_enable,
    output reg curr_mon_sw,
    output reg temp_mux_invalid,
    output reg [3:0] gate_drive_onehot,
    output reg gate_pol_negative,
    output reg gate_low_drive_en,
    output reg gate_high_drive_en,
    output reg chip_temp_mon_en
);

// ----------------------------------------
// decode helpers
// ----------------------------------------
// one-hot mux: bit0 prescaler, bit1 direct, bit2 monitor; 11 gives none
function [2:0] mux_decode;
    input [1:0] code;
    begin
        case (code)
            `QCFG_MUX_PRESC: mux_decode = 3'h1;
            `QCFG_MUX_DIRECT: mux_decode = 3'h2;
            `QCFG_MUX_MONITOR: mux_decode = 3'h4;
            default: mux_decode = 3'h0;
        endcase
    end
endfunction

// temperature pad allows only codes 000 and 010 when feeding monitor
function presc_bad;
    input [7:0] b;
    begin
        presc_bad = (b[`QCFG_MUX_MSB:`QCFG_MUX_LSB] == `QCFG_MUX_MONITOR) &&
            (b[`QCFG_PRESC_MSB:`QCFG_PRESC_LSB] != 3'h0) &&
            (b[`QCFG_PRESC_MSB:`QCFG_PRESC_LSB] != 3'h2);
    end
endfunction

// ----------------------------------------
// field helpers
// ----------------------------------------
// prescaler code of a pad byte
function [2:0] presc_field;
    input [7:0] b;
    begin
        presc_field = b[`QCFG_PRESC_MSB:`QCFG_PRESC_LSB];
    end
endfunction

// input selector code of a pad byte
function [1:0] mux_field;
    input [7:0] b;
    begin
        mux_field = b[`QCFG_MUX_MSB:`QCFG_MUX_LSB];
    end
endfunction

// drive code to one-hot: bit0 1 uA up to bit3 30 uA
function [3:0] drive_decode;
    input [1:0] code;
    begin
        case (code)
            2'h0: drive_decode = 4'h1;
            2'h1: drive_decode = 4'h2;
            2'h2: drive_decode = 4'h4;
            2'h3: drive_decode = 4'h8;
            default: drive_decode = 4'h1;
        endcase
    end
endfunction

// driver enable for one drive mode; off whenever driver-on is low
function drive_enable;
    input on;
    input high_sel;
    input want_high;
    begin
        drive_enable = on & (high_sel == want_high);
    end
endfunction

// readback mux over the four stored bytes
function [7:0] byte_select;
    input [1:0] a;
    input [7:0] v;
    input [7:0] c;
    input [7:0] g;
    input [7:0] t;
    begin
        case (a)
            `QCFG_ADDR_VOLT: byte_select = v;
            `QCFG_ADDR_CURR: byte_select = c;
            `QCFG_ADDR_GATE: byte_select = g;
            default: byte_select = t;
        endcase
    end
endfunction

// ----------------------------------------
// configuration storage
// ----------------------------------------
reg [7:0] volt_q;
reg [7:0] curr_q;
reg [7:0] gate_q;
reg [7:0] temp_q;

reg [7:0] volt_d;
reg [7:0] curr_d;
reg [7:0] gate_d;
reg [7:0] temp_d;

// a write replaces one whole byte; the other three keep their value
always @* begin
    volt_d = volt_q;
    curr_d = curr_q;
    gate_d = gate_q;
    temp_d = temp_q;
    if (cfg_wr) begin
        case (cfg_addr)
            `QCFG_ADDR_VOLT: volt_d = cfg_wdata;
            `QCFG_ADDR_CURR: curr_d = cfg_wdata;
            `QCFG_ADDR_GATE: gate_d = cfg_wdata;
            default: temp_d = cfg_wdata;
        endcase
    end
end

always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        volt_q <= `QCFG_PAD_RST;
        curr_q <= `QCFG_PAD_RST;
        gate_q <= `QCFG_GATE_RST;
        temp_q <= `QCFG_PAD_RST;
    end else begin
        volt_q <= volt_d;
        curr_q <= curr_d;
        gate_q <= gate_d;
        temp_q <= temp_d;
    end
end

// ----------------------------------------
// registered decode
// ----------------------------------------
// decode is pure logic on the stored bytes, cfg_addr and the two control inputs; the flops below keep every
// output glitch free towards the analog switches
reg [7:0] rdata_d;
reg [2:0] volt_presc_d;
reg [2:0] curr_presc_d;
reg [2:0] temp_presc_d;
reg [2:0] volt_mux_d;
reg [2:0] curr_mux_d;
reg [2:0] temp_mux_d;
reg [2:0] direct_d;
reg [2:0] pol_d;
reg [2:0] amp_d;
reg cmon_d;
reg invalid_d;
reg [3:0] drive_d;
reg gpol_d;
reg low_d;
reg high_d;
reg tmon_d;

// ----------------------------------------
// readback
// ----------------------------------------
// read select needs no strobe; data shows one clock after the address
always @* begin
    rdata_d = byte_select(cfg_addr, volt_q, curr_q, gate_q, temp_q);
end

// ----------------------------------------
// voltage pad
// ----------------------------------------
// code passes through; analog ladder doubles per step
always @* begin
    volt_presc_d = presc_field(volt_q);
    volt_mux_d = mux_decode(mux_field(volt_q));
    cmon_d = volt_q[`QCFG_CMON_BIT];
end

// ----------------------------------------
// current pad
// ----------------------------------------
always @* begin
    curr_presc_d = presc_field(curr_q);
    curr_mux_d = mux_decode(mux_field(curr_q));
end

// ----------------------------------------
// temperature pad
// ----------------------------------------
// a bad range only raises a flag; the analog side still gets the code
always @* begin
    temp_presc_d = presc_field(temp_q);
    temp_mux_d = mux_decode(mux_field(temp_q));
    invalid_d = presc_bad(temp_q);
end

// ----------------------------------------
// switches shared by the three pads
// ----------------------------------------
// bit order of each vector: 0 voltage, 1 current, 2 temperature
always @* begin
    direct_d = {temp_q[`QCFG_DIRECT_BIT], curr_q[`QCFG_DIRECT_BIT],
        volt_q[`QCFG_DIRECT_BIT]};
    // temperature pad forced positive; a stray bit 6 is ignored
    pol_d = {1'b0, curr_q[`QCFG_POL_BIT], volt_q[`QCFG_POL_BIT]};
    amp_d = {temp_q[`QCFG_AMP_BIT], curr_q[`QCFG_AMP_BIT],
        volt_q[`QCFG_AMP_BIT]};
end

// ----------------------------------------
// gate driver
// ----------------------------------------
// enables follow the driver-on level with one clock of lag
always @* begin
    drive_d = drive_decode(gate_q[`QCFG_DRV_MSB:`QCFG_DRV_LSB]);
    gpol_d = gate_q[`QCFG_GPOL_BIT];
    low_d = drive_enable(gate_driver_on, gate_q[`QCFG_HIGH_BIT],
        1'b0);
    high_d = drive_enable(gate_driver_on, gate_q[`QCFG_HIGH_BIT],
        1'b1);
    // mixed levels on the two controls leave the monitor off
    tmon_d = gate_q[`QCFG_TMON_BIT] & temp_monitor_power_ctl;
end

// ----------------------------------------
// output registers
// ----------------------------------------
// outputs lag storage by one clock so every output leaves a flip-flop
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        cfg_rdata <= 8'h00;
        volt_presc_sel <= 3'h0;
        curr_presc_sel <= 3'h0;
        temp_presc_sel <= 3'h0;
        volt_mux_sel <= 3'h1;
        curr_mux_sel <= 3'h1;
        temp_mux_sel <= 3'h1;
        direct_sw <= 3'h0;
        pol_negative <= 3'h0;
        amp_enable <= 3'h0;
        curr_mon_sw <= 1'b0;
        temp_mux_invalid <= 1'b0;
        gate_drive_onehot <= 4'h1;
        gate_pol_negative <= 1'b0;
        gate_low_drive_en <= 1'b0;
        gate_high_drive_en <= 1'b0;
        chip_temp_mon_en <= 1'b0;
    end else begin
        cfg_rdata <= rdata_d;
        volt_presc_sel <= volt_presc_d;
        curr_presc_sel <= curr_presc_d;
        temp_presc_sel <= temp_presc_d;
        volt_mux_sel <= volt_mux_d;
        curr_mux_sel <= curr_mux_d;
        temp_mux_sel <= temp_mux_d;
        direct_sw <= direct_d;
        pol_negative <= pol_d;
        amp_enable <= amp_d;
        curr_mon_sw <= cmon_d;
        temp_mux_invalid <= invalid_d;
        gate_drive_onehot <= drive_d;
        gate_pol_negative <= gpol_d;
        gate_low_drive_en <= low_d;
        gate_high_drive_en <= high_d;
        chip_temp_mon_en <= tmon_d;
    end
end

endmodule

`default_nettype wire

// [tb/quad_chk.sv]
`default_nettype none
module quad_chk (
    input wire clk_sys, rst, cfg_wr, gate_driver_on, temp_monitor_power_ctl,
    input wire [1:0] cfg_addr,
    input wire [7:0] cfg_wdata,
    input wire [2:0] volt_presc_sel, volt_mux_sel, amp_enable,
    input wire [3:0] gate_drive_onehot,
    input wire gate_low_drive_en, gate_high_drive_en, chip_temp_mon_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire w0 = cfg_wr && cfg_addr == 2'h0;
    wire w2 = cfg_wr && cfg_addr == 2'h2;
    wire w3 = cfg_wr && cfg_addr == 2'h3;
    a_presc_decode: assert property (w0 |=> ##1
        volt_presc_sel == $past(cfg_wdata[2:0], 2)) else $error("range");
    a_mux_onehot: assert property (w0 |=> ##1
        volt_mux_sel == 3'h1 << $past(cfg_wdata[4:3], 2)) else $error("mux");
    a_amp_power: assert property (w3 |=> ##1
        amp_enable[2] == $past(cfg_wdata[7], 2)) else $error("amp");
    a_drive_strength: assert property (w2 |=> ##1
        gate_drive_onehot == 4'h1 << $past(cfg_wdata[3:2], 2))
        else $error("drv");
    a_driver_off: assert property (!gate_driver_on |=>
        !(gate_low_drive_en || gate_high_drive_en)) else $error("gate on");
    a_tmon_power: assert property (!temp_monitor_power_ctl |=>
        !chip_temp_mon_en) else $error("tmon");
    a_reset_default: assert property ($fell(rst) |->
        volt_mux_sel == 3'h1 && gate_drive_onehot == 4'h1) else $error("rst");
    a_hold_value: assert property (!cfg_wr ##1 !cfg_wr |=>
        $stable(volt_presc_sel)) else $error("hold");
    c_high: cover property (w2 ##2 gate_high_drive_en);
    c_temp: cover property (w3 ##2 amp_enable[2]);
    c_tmon: cover property (chip_temp_mon_en);
endmodule
bind analog_quad_config_decode quad_chk u_quad_chk (.*);
`default_nettype wire

// [tb/cfg_writer.sv]
`default_nettype none
module cfg_writer (
    input wire logic clk_sys,
    output var logic cfg_wr = 1'h0,
    output var logic [1:0] cfg_addr = 2'h0,
    output var logic [7:0] cfg_wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sent;
    // writer never sends illegal codes, so the design need not police them
    task wr(input logic [1:0] a, input logic [7:0] d);
        if (a != 2'h2 && d[4:3] == 2'h3) d[4] = 1'h0;
        if (a == 2'h3) d[6] = 1'h0;
        if (a == 2'h3 && d[4:3] == 2'h2) d[2:0] = d[2:0] & 3'h2;
        sent = d;
        @(posedge clk_sys);
        #1 cfg_wr = 1'h1;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge clk_sys);
        #1 cfg_wr = 1'h0;
        cfg_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst, o, p;
    logic [7:0] d;
    logic [7:0] m [4];
    logic [1:0] a;
    int bad_count = 0;
    int compares = 0;
    int seed_v;
    wire cfg_wr;
    wire [1:0] cfg_addr;
    wire [7:0] cfg_wdata, cfg_rdata;
    wire [36:0] q;
    cfg_writer u_cfg_writer (.clk_sys(clk_sys), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
    analog_quad_config_decode u_analog_quad_config_decode (.clk_sys(clk_sys),
        .rst(rst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .gate_driver_on(o), .temp_monitor_power_ctl(p),
        .volt_presc_sel(q[36:34]), .curr_presc_sel(q[33:31]),
        .temp_presc_sel(q[30:28]), .volt_mux_sel(q[27:25]),
        .curr_mux_sel(q[24:22]), .temp_mux_sel(q[21:19]), .direct_sw(q[18:16]),
        .pol_negative(q[15:13]), .amp_enable(q[12:10]), .curr_mon_sw(q[9]),
        .temp_mux_invalid(q[8]), .gate_drive_onehot(q[7:4]),
        .gate_pol_negative(q[3]), .gate_low_drive_en(q[2]),
        .gate_high_drive_en(q[1]), .chip_temp_mon_en(q[0]));
    function logic [36:0] ex(input logic [7:0] v, c, g, t);
        ex = {v[2:0], c[2:0], t[2:0], 3'h1 << v[4:3], 3'h1 << c[4:3],
            3'h1 << t[4:3], t[5], c[5], v[5], 1'h0, c[6], v[6], t[7], c[7],
            v[7], v[4], 1'h0, 4'h1 << g[3:2], g[6], o & ~g[7], o & g[7],
            g[0] & p};
    endfunction
    task chk(input logic [36:0] got, exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        rst = 1'h1;
        o = 1'h0;
        p = 1'h0;
        m = '{default: 8'h00};
        seed_v = $urandom(32'h525d_c871);
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'h0;
        @(posedge clk_sys);
        #1 chk(q, ex(m[0], m[1], m[2], m[3]));
        for (int i = 0; i < 60; i++) begin
            // first writes sweep every drive code with high drive and monitor on
            a = (i < 4) ? 2'h2 : 2'($urandom);
            d = (i < 4) ? {4'h8, i[1:0], 2'h1} : 8'($urandom);
            o = (i < 4) ? 1'h1 : 1'($urandom);
            p = (i < 4) ? 1'h1 : 1'($urandom);
            u_cfg_writer.wr(a, d);
            m[a] = u_cfg_writer.sent;
            repeat (2) @(posedge clk_sys);
            #1 chk(q,
                ex(m[0], m[1], m[2], m[3]));
            chk({29'h0, cfg_rdata}, {29'h0, m[a]});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
